// ### rtl/program_address_sequencer.sv
// What this block does
// - sequential step: counter plus one or two
// - branch loads immediate word after opcode
// - call pushes next address, then loads target
// - return pops stack top into counter
// - interrupt loads its vector slot address
// - accumulator branch/call use low sixteen bits
// - accumulator via data bus, immediates via program
// - eight-deep sixteen-bit return stack
// - automatic push adds no cycles
// - accumulator push/pop move low half
// - memory push/pop exchange data words
// - push shifts down, bottom lost silently
// - pop shifts up, bottom value kept
// - hidden one-entry sixteen-bit micro stack
// - two-operand ops save/restore fetch address
// - repeats step first operand via counter
// - micro stack unreachable by instructions
// - sixteen-bit repeat count for next instruction
// - holding register drives program address bus
// - table/block return uses micro stack
`default_nettype none
module program_address_sequencer (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // decoder request, one operation per cycle
  input wire logic op_valid_in,
  input wire logic [3:0] op_code_in,
  input wire logic two_word_in,
  // operand sources
  input wire logic [15:0] program_read_bus_in,
  input wire logic [15:0] data_read_bus_in,
  input wire logic [15:0] vector_addr_in,
  // two-operand instruction ends this cycle
  input wire logic micro_done_in,
  // program memory side
  output logic [15:0] program_address_bus_out,
  // stack data back to datapath
  output logic [15:0] acc_low_out,
  output logic acc_low_valid_out,
  output logic [15:0] data_mem_out,
  output logic data_mem_valid_out,
  // status
  output logic [15:0] program_counter_out,
  output logic [15:0] repeat_count_out,
  output logic repeat_active_out,
  output logic micro_busy_out
);
  ////////////////////////////////////////////////////////////////////////
  pas_pkg::pas_op_t op;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic [15:0] fetch_address_hold_q;
  logic [15:0] micro_return_stack_q;
  logic [15:0] stack_top;
  logic [15:0] rpt_count;
  logic rpt_active;
  logic stack_push;
  logic stack_pop;
  logic [15:0] stack_push_data;
  logic rpt_load;
  logic rpt_step;
  pas_pkg::micro_state_t micro_state_q;
  logic [15:0] acc_low_q;
  logic acc_low_valid_q;
  logic [15:0] data_mem_q;
  logic data_mem_valid_q;
  logic [15:0] repeat_count_q;
  logic repeat_active_q;
  logic micro_busy_q;
  logic [15:0] pc_out_q;

  assign op = op_valid_in ? pas_pkg::pas_op_t'(op_code_in) : pas_pkg::OP_HOLD;

  function automatic logic [15:0] seq_step(input logic [15:0] base, input logic two);
    seq_step = two ? base + pas_pkg::ADDR_TWO : base + pas_pkg::ADDR_ONE;
  endfunction : seq_step

  ////////////////////////////////////////////////////////////////////////
  // push/pop requests to the main stack; the micro stack is never a target
  always_comb begin
    stack_push = 1'b0;
    stack_pop = 1'b0;
    stack_push_data = pas_pkg::ZERO_WORD;
    unique case (op)
      pas_pkg::OP_CALL, pas_pkg::OP_CALL_ACC: begin
        stack_push = 1'b1;
        stack_push_data = seq_step(pc_q, two_word_in);
      end
      pas_pkg::OP_INTR: begin
        stack_push = 1'b1;
        stack_push_data = pc_q;
      end
      pas_pkg::OP_PUSH_ACC, pas_pkg::OP_PUSH_MEM: begin
        stack_push = 1'b1;
        stack_push_data = data_read_bus_in;
      end
      pas_pkg::OP_RETURN, pas_pkg::OP_POP_ACC, pas_pkg::OP_POP_MEM: begin
        stack_pop = 1'b1;
      end
      default: begin
      end
    endcase
  end

  return_stack return_stack_inst (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .push_in(stack_push),
    .pop_in(stack_pop),
    .push_data_in(stack_push_data),
    .stack_top_out(stack_top)
  );

  ////////////////////////////////////////////////////////////////////////
  assign rpt_load = (op == pas_pkg::OP_RPT_LOAD);
  assign rpt_step = (micro_state_q == pas_pkg::MS_RUN) && op_valid_in;

  repeat_counter repeat_counter_inst (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .load_in(rpt_load),
    .load_value_in(program_read_bus_in),
    .step_in(rpt_step),
    .count_out(rpt_count),
    .active_out(rpt_active)
  );

  ////////////////////////////////////////////////////////////////////////
  // next program counter
  always_comb begin
    pc_d = pc_q;
    unique case (op)
      pas_pkg::OP_SEQ: begin
        pc_d = seq_step(pc_q, two_word_in);
      end
      pas_pkg::OP_HOLD: begin
        pc_d = pc_q;
      end
      pas_pkg::OP_BRANCH, pas_pkg::OP_CALL: begin
        pc_d = program_read_bus_in;
      end
      pas_pkg::OP_RETURN: begin
        pc_d = stack_top;
      end
      pas_pkg::OP_INTR: begin
        pc_d = vector_addr_in;
      end
      pas_pkg::OP_BR_ACC, pas_pkg::OP_CALL_ACC: begin
        pc_d = data_read_bus_in;
      end
      pas_pkg::OP_PUSH_ACC, pas_pkg::OP_POP_ACC, pas_pkg::OP_PUSH_MEM,
      pas_pkg::OP_POP_MEM, pas_pkg::OP_RPT_LOAD: begin
        // stack and repeat ops still advance the fetch
        pc_d = seq_step(pc_q, two_word_in);
      end
      pas_pkg::OP_MICRO_OP: begin
        pc_d = program_read_bus_in;
      end
      default: begin
        // unused codes act as a dummy cycle
        pc_d = pc_q;
      end
    endcase
    // while a two-operand op runs, the counter walks the first operand
    if (micro_state_q == pas_pkg::MS_RUN) begin
      pc_d = op_valid_in ? pc_q + pas_pkg::ADDR_ONE : pc_q;
    end
    if (micro_state_q == pas_pkg::MS_FINISH) begin
      pc_d = micro_return_stack_q;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pc_q <= pas_pkg::RESET_ADDR;
    end else begin
      pc_q <= pc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // micro stack: written and read only by this sequencer, no port reaches it
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      micro_state_q <= pas_pkg::MS_IDLE;
    end else begin
      unique case (micro_state_q)
        pas_pkg::MS_IDLE: begin
          if (op == pas_pkg::OP_MICRO_OP) begin
            micro_state_q <= pas_pkg::MS_RUN;
          end
        end
        pas_pkg::MS_RUN: begin
          if (micro_done_in && !rpt_active) begin
            micro_state_q <= pas_pkg::MS_FINISH;
          end
        end
        pas_pkg::MS_FINISH: begin
          micro_state_q <= pas_pkg::MS_IDLE;
        end
        default: micro_state_q <= pas_pkg::MS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // single entry: written only from idle, so a two-operand op arriving mid-run leaves it alone
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      micro_return_stack_q <= pas_pkg::ZERO_WORD;
    end else if (micro_state_q == pas_pkg::MS_IDLE && op == pas_pkg::OP_MICRO_OP) begin
      micro_return_stack_q <= seq_step(pc_q, two_word_in);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // holding register drives the address bus; dummy cycles reuse it
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      fetch_address_hold_q <= pas_pkg::RESET_ADDR;
    end else if (op != pas_pkg::OP_HOLD || micro_state_q != pas_pkg::MS_IDLE) begin
      fetch_address_hold_q <= pc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pop result to accumulator; word holds until the next pop
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      acc_low_q <= pas_pkg::ZERO_WORD;
      acc_low_valid_q <= 1'b0;
    end else begin
      acc_low_valid_q <= (op == pas_pkg::OP_POP_ACC);
      if (op == pas_pkg::OP_POP_ACC) begin
        acc_low_q <= stack_top;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pop result to data memory
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      data_mem_q <= pas_pkg::ZERO_WORD;
      data_mem_valid_q <= 1'b0;
    end else begin
      data_mem_valid_q <= (op == pas_pkg::OP_POP_MEM);
      if (op == pas_pkg::OP_POP_MEM) begin
        data_mem_q <= stack_top;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status mirrors, registered so every output comes from a flop
  // cost: each one lags its source by a cycle
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      repeat_count_q <= pas_pkg::ZERO_WORD;
    end else begin
      repeat_count_q <= rpt_count;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      repeat_active_q <= 1'b0;
    end else begin
      repeat_active_q <= rpt_active;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      micro_busy_q <= 1'b0;
    end else begin
      micro_busy_q <= (micro_state_q != pas_pkg::MS_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter mirror for debug only, the bus itself comes from the hold
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pc_out_q <= pas_pkg::RESET_ADDR;
    end else begin
      pc_out_q <= pc_q;
    end
  end

  assign program_address_bus_out = fetch_address_hold_q;
  assign acc_low_out = acc_low_q;
  assign acc_low_valid_out = acc_low_valid_q;
  assign data_mem_out = data_mem_q;
  assign data_mem_valid_out = data_mem_valid_q;
  assign program_counter_out = pc_out_q;
  assign repeat_count_out = repeat_count_q;
  assign repeat_active_out = repeat_active_q;
  assign micro_busy_out = micro_busy_q;
endmodule : program_address_sequencer
`default_nettype wire

// ### rtl/pas_pkg.sv
`default_nettype none
package pas_pkg;
  localparam int ADDR_W = 16;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam logic [15:0] RESET_ADDR = 16'h0000;
  localparam logic [15:0] ADDR_ONE = 16'h0001;
  localparam logic [15:0] ADDR_TWO = 16'h0002;
  localparam logic [15:0] ZERO_WORD = 16'h0000;

  // address-generation operations requested by the decoder
  typedef enum logic [3:0] {
    OP_SEQ        = 4'h0,
    OP_HOLD       = 4'h1,
    OP_BRANCH     = 4'h2,
    OP_CALL       = 4'h3,
    OP_RETURN     = 4'h4,
    OP_INTR       = 4'h5,
    OP_BR_ACC     = 4'h6,
    OP_CALL_ACC   = 4'h7,
    OP_PUSH_ACC   = 4'h8,
    OP_POP_ACC    = 4'h9,
    OP_PUSH_MEM   = 4'hA,
    OP_POP_MEM    = 4'hB,
    OP_MICRO_OP   = 4'hC,
    OP_RPT_LOAD   = 4'hD
  } pas_op_t;

  // micro-op sequencing states, gray along idle -> run -> finish
  typedef enum logic [1:0] {
    MS_IDLE   = 2'b00,
    MS_RUN    = 2'b01,
    MS_FINISH = 2'b11
  } micro_state_t;
endpackage : pas_pkg
`default_nettype wire

// ### rtl/return_stack.sv
`default_nettype none
module return_stack (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // control
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic [15:0] push_data_in,
  // state
  output logic [15:0] stack_top_out
);
  logic [15:0] level_q [pas_pkg::STACK_DEPTH];

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < pas_pkg::STACK_DEPTH; i++) begin
        level_q[i] <= pas_pkg::ZERO_WORD;
      end
    end else if (push_in) begin
      // bottom entry falls off silently, no overflow flag
      level_q[0] <= push_data_in;
      for (int i = 1; i < pas_pkg::STACK_DEPTH; i++) begin
        level_q[i] <= level_q[i-1];
      end
    end else if (pop_in) begin
      for (int i = 0; i < pas_pkg::STACK_DEPTH - 1; i++) begin
        level_q[i] <= level_q[i+1];
      end
      // bottom keeps its value so deep pops repeat it
      level_q[pas_pkg::STACK_DEPTH-1] <= level_q[pas_pkg::STACK_DEPTH-1];
    end
  end

  assign stack_top_out = level_q[0];
endmodule : return_stack
`default_nettype wire

// ### rtl/repeat_counter.sv
`default_nettype none
module repeat_counter (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // control
  input wire logic load_in,
  input wire logic [15:0] load_value_in,
  input wire logic step_in,
  // state
  output logic [15:0] count_out,
  output logic active_out
);
  logic [15:0] repeat_count_q;

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      repeat_count_q <= pas_pkg::ZERO_WORD;
    end else if (load_in) begin
      repeat_count_q <= load_value_in;
    end else if (step_in && repeat_count_q != pas_pkg::ZERO_WORD) begin
      repeat_count_q <= repeat_count_q - pas_pkg::ADDR_ONE;
    end
  end

  assign count_out = repeat_count_q;
  assign active_out = (repeat_count_q != pas_pkg::ZERO_WORD);
endmodule : repeat_counter
`default_nettype wire

// ### sim/pas_monitor.sv
`default_nettype none
module pas_monitor (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // decoder request
  input wire logic op_valid_in,
  input wire logic [3:0] op_code_in,
  input wire logic two_word_in,
  input wire logic [15:0] program_read_bus_in,
  input wire logic [15:0] data_read_bus_in,
  input wire logic [15:0] vector_addr_in,
  // watched outputs
  input wire logic [15:0] program_address_bus_out,
  input wire logic acc_low_valid_out,
  input wire logic [15:0] repeat_count_out,
  input wire logic micro_busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // micro sequence overrides decode, so most checks skip it
  wire logic go = op_valid_in && !micro_busy_out;
  wire logic [3:0] op = op_code_in;
  wire logic [15:0] adr = program_address_bus_out;
  ////////////////////////////////////////
  chk_hold_keeps_addr: assert property (!op_valid_in && !micro_busy_out |=> $stable(adr))
    else $error("address moved in a dummy cycle");
  chk_step_one: assert property (go && op == pas_pkg::OP_SEQ && !two_word_in
    |=> adr == $past(adr) + 16'h0001) else $error("sequential step wrong");
  chk_branch_imm: assert property (go && (op == pas_pkg::OP_BRANCH ||
    op == pas_pkg::OP_CALL) |=> adr == $past(program_read_bus_in)) else $error("bad target");
  chk_acc_target: assert property (go && (op == pas_pkg::OP_BR_ACC ||
    op == pas_pkg::OP_CALL_ACC) |=> adr == $past(data_read_bus_in)) else $error("bad acc target");
  chk_vector_load: assert property (go && op == pas_pkg::OP_INTR
    |=> adr == $past(vector_addr_in)) else $error("bad vector address");
  chk_pop_pulse: assert property (acc_low_valid_out ==
    $past(op_valid_in && op == pas_pkg::OP_POP_ACC)) else $error("pop pulse wrong");
  chk_call_return: assert property ((go && op == pas_pkg::OP_CALL && two_word_in)
    ##1 !op_valid_in ##1 (op_valid_in && op == pas_pkg::OP_RETURN)
    |=> adr == $past(adr, 3) + 16'h0002) else $error("return address wrong");
  chk_repeat_load: assert property (go && op == pas_pkg::OP_RPT_LOAD
    |=> ##1 repeat_count_out == $past(program_read_bus_in, 2)) else $error("repeat count");
  cover property (go && op == pas_pkg::OP_MICRO_OP);
  cover property (acc_low_valid_out);
  cover property (micro_busy_out ##1 !micro_busy_out);
endmodule : pas_monitor
`default_nettype wire

// ### sim/pas_far_side.sv
`default_nettype none
module pas_far_side (
  // clock
  input wire logic mclk_in,
  // stack words handed to the datapath
  input wire logic acc_valid_in,
  input wire logic [15:0] acc_in,
  input wire logic mem_valid_in,
  input wire logic [15:0] mem_in,
  // captured words
  output logic [15:0] acc_word_out,
  output logic [15:0] mem_word_out,
  output logic [7:0] pulses_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] count_q = 8'h00;
  // counting pulses shows a stretched pulse as a double count
  // strobes are unknown before the first reset edge; count only real highs
  always @(posedge mclk_in) begin
    if (acc_valid_in === 1'b1) acc_word_out <= acc_in;
    if (mem_valid_in === 1'b1) mem_word_out <= mem_in;
    count_q <= count_q + 8'(acc_valid_in === 1'b1) + 8'(mem_valid_in === 1'b1);
  end
  assign pulses_out = count_q;
endmodule : pas_far_side
`default_nettype wire

// ### sim/program_address_sequencer_test.sv
`default_nettype none
module program_address_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic op_valid_in = 1'b0;
  logic [3:0] op_code_in = 4'h0;
  logic two_word_in = 1'b0;
  logic [15:0] program_read_bus_in = 16'h0000;
  logic [15:0] data_read_bus_in = 16'h0000;
  logic [15:0] vector_addr_in = 16'h0002;
  logic micro_done_in = 1'b0;
  logic [15:0] program_address_bus_out, acc_low_out, data_mem_out, program_counter_out;
  logic [15:0] repeat_count_out, acc_word, mem_word;
  logic acc_low_valid_out, data_mem_valid_out, repeat_active_out, micro_busy_out;
  logic [7:0] pulses;
  int n_mismatch = 0;
  int compares = 0;
  always #5 mclk_in = ~mclk_in;
  program_address_sequencer program_address_sequencer_inst (.*);
  pas_far_side pas_far_side_inst (.mclk_in(mclk_in), .acc_valid_in(acc_low_valid_out),
    .acc_in(acc_low_out), .mem_valid_in(data_mem_valid_out), .mem_in(data_mem_out),
    .acc_word_out(acc_word), .mem_word_out(mem_word), .pulses_out(pulses));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one op, then a dummy cycle so the strobe never doubles up
  task automatic go(input logic [3:0] op, input logic tw, input logic [15:0] p, d, exp);
    @(posedge mclk_in);
    op_valid_in <= 1'b1;
    op_code_in <= op;
    two_word_in <= tw;
    program_read_bus_in <= p;
    data_read_bus_in <= d;
    @(posedge mclk_in);
    op_valid_in <= 1'b0;
    #1;
    if (exp !== 16'hFFFF) check("program address", program_address_bus_out, exp);
  endtask : go
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : wait_n
  task automatic flow_test;
    check("reset address", program_address_bus_out, 16'h0000);
    go(pas_pkg::OP_SEQ, 1'b0, 16'h0000, 16'h0000, 16'h0001);
    go(pas_pkg::OP_SEQ, 1'b1, 16'h0000, 16'h0000, 16'h0003);
    wait_n(3);
    check("dummy address", program_address_bus_out, 16'h0003);
    go(pas_pkg::OP_BRANCH, 1'b1, 16'h1234, 16'h0BAD, 16'h1234);
    go(pas_pkg::OP_BR_ACC, 1'b0, 16'h0BAD, 16'h4321, 16'h4321);
    wait_n(1);
    check("program counter", program_counter_out, 16'h4321);
  endtask : flow_test
  task automatic call_test;
    go(pas_pkg::OP_CALL, 1'b1, 16'h2000, 16'h0BAD, 16'h2000);
    go(pas_pkg::OP_RETURN, 1'b0, 16'h0BAD, 16'h0BAD, 16'h4323);
    go(pas_pkg::OP_CALL_ACC, 1'b0, 16'h0BAD, 16'h3000, 16'h3000);
    go(pas_pkg::OP_RETURN, 1'b0, 16'h0BAD, 16'h0BAD, 16'h4324);
    go(pas_pkg::OP_INTR, 1'b0, 16'h0BAD, 16'h0BAD, 16'h0002);
    go(pas_pkg::OP_RETURN, 1'b0, 16'h0BAD, 16'h0BAD, 16'h4324);
  endtask : call_test
  // nine pushes overflow by one; ten pops run past the bottom
  task automatic stack_test;
    for (int i = 1; i <= 9; i++) go(pas_pkg::OP_PUSH_ACC, 1'b0, 16'h0000, 16'(i), 16'hFFFF);
    for (int i = 9; i >= 0; i--) begin
      go(pas_pkg::OP_POP_ACC, 1'b0, 16'h0000, 16'h0000, 16'hFFFF);
      check("pop word", acc_low_out, (i > 2) ? 16'(i) : 16'h0002);
      check("pop pulse", acc_low_valid_out, 16'h0001);
    end
    go(pas_pkg::OP_PUSH_MEM, 1'b0, 16'h0000, 16'hBEEF, 16'hFFFF);
    go(pas_pkg::OP_POP_MEM, 1'b0, 16'h0000, 16'h0000, 16'hFFFF);
    check("memory word", data_mem_out, 16'hBEEF);
    check("memory pulse", 16'(data_mem_valid_out), 16'h0001);
    wait_n(2);
    check("far acc word", acc_word, 16'h0002);
    check("far mem word", mem_word, 16'hBEEF);
    check("pulse count", 16'(pulses), 16'h000B);
  endtask : stack_test
  task automatic micro_test;
    logic [15:0] ret;
    int n;
    go(pas_pkg::OP_RPT_LOAD, 1'b0, 16'h0002, 16'h0000, 16'hFFFF);
    ret = program_address_bus_out + 16'h0001;
    wait_n(1);
    check("repeat count", repeat_count_out, 16'h0002);
    check("repeat active", 16'(repeat_active_out), 16'h0001);
    go(pas_pkg::OP_MICRO_OP, 1'b0, 16'h0500, 16'h0000, 16'h0500);
    go(pas_pkg::OP_SEQ, 1'b0, 16'h0000, 16'h0000, 16'h0501);
    check("micro busy", 16'(micro_busy_out), 16'h0001);
    micro_done_in <= 1'b1;
    n = 0;
    while (program_address_bus_out !== ret && n < 8) begin
      go(pas_pkg::OP_SEQ, 1'b0, 16'h0000, 16'h0000, 16'hFFFF);
      n++;
    end
    micro_done_in <= 1'b0;
    check("micro return", program_address_bus_out, ret);
    wait_n(3);
    check("repeat spent", repeat_count_out, 16'h0000);
    check("micro idle", 16'(micro_busy_out), 16'h0000);
  endtask : micro_test
  task automatic test_done;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    #1;
    flow_test;
    call_test;
    stack_test;
    micro_test;
    test_done;
  end
  // tests need about a hundred cycles; ten thousand means a hang
  initial begin
    #100000;
    n_mismatch++;
    test_done;
  end
endmodule : program_address_sequencer_test
bind program_address_sequencer pas_monitor pas_monitor_inst (.*);
`default_nettype wire
